// ==== dsm_ctrl.sv ====
// module: data signal modulator control, source mux, high carrier and output mixing
//
// Operation
// R1 - enable bit mixes; clear gives no output
// R2 - polarity bit inverts output, idles high
// R3 - read-only status shows modulated output value
// R4 - software ignores status for fast signals
// R5 - software bit modulates only when selected
// R6 - four-bit field picks the modulator source
// R7 - modulator code 1001 connects nothing
// R8 - high carrier invert before mixing
// R9 - sync waits high carrier falling edge
// R10 - no sync switches away at once
// R11 - four-bit field picks the high carrier
// R12 - carrier code 1001 connects nothing
// R13 - unused control bits read zero
// R14 - source register upper nibble reads zero
// R15 - select fields keep value; control resets
// R16 - output is carrier ANDed with modulator
// R17 - modulator high uses high, low uses low
// R18 - sync carrier held until its falling edge
// R19 - any reset leaves the modulator disabled
`timescale 1ns/100ps
`default_nettype none

module dsm_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire dsm_pkg::dsm_periph_t periph_in,
  input wire dsm_pkg::dsm_async_t async_in,
  input wire dsm_pkg::dsm_low_t low_in,
  output logic modulated_out
);

  // ----------------------------------------------------------------
  // synchronised pins and foreign clocks
  // ----------------------------------------------------------------
  dsm_pkg::dsm_async_t async_s;

  // pins and foreign clocks pass four flops before any use
  dsm_sync #(
    .WIDTH(dsm_pkg::ASYNC_W)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(async_in),
    .sync_out(async_s)
  );

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  // software-visible register bits
  logic enable_q, enable_d;
  logic polarity_q, polarity_d;
  logic swbit_q, swbit_d;
  logic [3:0] mod_sel_q, mod_sel_d;
  logic [3:0] car_sel_q, car_sel_d;
  logic car_inv_q, car_inv_d;
  logic car_sync_q, car_sync_d;
  logic [7:0] rdata_q, rdata_d;

  // ----------------------------------------------------------------
  // mixing state
  // ----------------------------------------------------------------
  // sync gates, carrier history and output flop
  logic high_act_q, high_act_d;
  logic low_act_q, low_act_d;
  logic carh_prev_q, carh_prev_d;
  logic carl_prev_q, carl_prev_d;
  logic out_q, out_d;

  // selected signals and effective gates
  logic modulator;
  logic carh;
  logic carl;
  logic high_act;
  logic low_act;
  logic mixed;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // control register image with unused bits at zero
  function automatic logic [7:0] ctrl_image(
    input logic en,
    input logic pol,
    input logic stat,
    input logic sw
  );
    logic [7:0] v;
    v = dsm_pkg::READ_ZERO;
    v[dsm_pkg::CTRL_ENABLE_POS] = en;
    v[dsm_pkg::CTRL_POLARITY_POS] = pol;
    v[dsm_pkg::CTRL_STATUS_POS] = stat;
    v[dsm_pkg::CTRL_SWBIT_POS] = sw;
    return v;
  endfunction

  // carrier hold state: follow at once, or only on a falling edge
  // a synced carrier that never falls keeps its old gate
  function automatic logic carrier_gate(
    input logic want,
    input logic sync_en,
    input logic held,
    input logic now,
    input logic prev
  );
    logic g;
    g = held;
    if (!sync_en || (prev && !now)) begin
      g = want;
    end
    return g;
  endfunction

  // register index match, shared by write and read decode
  function automatic logic addr_hit(
    input logic [1:0] addr,
    input logic [1:0] want
  );
    return addr == want;
  endfunction

  // ----------------------------------------------------------------
  // modulator source select
  // ----------------------------------------------------------------
  always_comb begin
    modulator = 1'b0;
    if (!enable_q) begin
      modulator = swbit_q; // disabled forces the software bit
    end else begin
      case (dsm_pkg::dsm_mod_sel_t'(mod_sel_q)) // see R6
        dsm_pkg::MS_SOFTWARE: modulator = swbit_q; // see R5
        dsm_pkg::MS_PIN: modulator = async_s.mod_pin;
        dsm_pkg::MS_CAPTURE_COMPARE_ONE: modulator = periph_in.capture_compare_one;
        dsm_pkg::MS_CAPTURE_COMPARE_TWO: modulator = periph_in.capture_compare_two;
        dsm_pkg::MS_PULSE_WIDTH_UNIT_FIVE: modulator = periph_in.pulse_width_unit_five;
        dsm_pkg::MS_PULSE_WIDTH_UNIT_SIX: modulator = periph_in.pulse_width_unit_six;
        dsm_pkg::MS_CMP1: modulator = periph_in.cmp1;
        dsm_pkg::MS_CMP2: modulator = periph_in.cmp2;
        dsm_pkg::MS_SDO: modulator = periph_in.sdo;
        dsm_pkg::MS_RESERVED: modulator = 1'b0; // see R7
        dsm_pkg::MS_TX: modulator = periph_in.tx;
        dsm_pkg::MS_NCO: modulator = periph_in.nco;
        dsm_pkg::MS_LOGIC_CELL_ONE: modulator = periph_in.clc[0];
        dsm_pkg::MS_CLC2: modulator = periph_in.clc[1];
        dsm_pkg::MS_CLC3: modulator = periph_in.clc[2];
        dsm_pkg::MS_LOGIC_CELL_FOUR: modulator = periph_in.clc[3];
        default: modulator = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // high carrier select and polarity
  // ----------------------------------------------------------------
  always_comb begin
    carh = 1'b0;
    case (dsm_pkg::dsm_car_sel_t'(car_sel_q)) // see R11
      dsm_pkg::CH_GROUND: carh = 1'b0;
      dsm_pkg::CH_PIN1: carh = async_s.car_pin1;
      dsm_pkg::CH_PIN2: carh = async_s.car_pin2;
      dsm_pkg::CH_REFCLK: carh = async_s.refclk;
      dsm_pkg::CH_CAPTURE_COMPARE_ONE: carh = periph_in.capture_compare_one;
      dsm_pkg::CH_CAPTURE_COMPARE_TWO: carh = periph_in.capture_compare_two;
      dsm_pkg::CH_PULSE_WIDTH_UNIT_FIVE: carh = periph_in.pulse_width_unit_five;
      dsm_pkg::CH_PULSE_WIDTH_UNIT_SIX: carh = periph_in.pulse_width_unit_six;
      dsm_pkg::CH_NCO: carh = periph_in.nco;
      dsm_pkg::CH_RESERVED: carh = 1'b0; // see R12
      dsm_pkg::CH_SYSCLK: carh = async_s.sysclk;
      dsm_pkg::CH_FASTOSC: carh = async_s.fastosc;
      dsm_pkg::CH_LOGIC_CELL_ONE: carh = periph_in.clc[0];
      dsm_pkg::CH_CLC2: carh = periph_in.clc[1];
      dsm_pkg::CH_CLC3: carh = periph_in.clc[2];
      dsm_pkg::CH_LOGIC_CELL_FOUR: carh = periph_in.clc[3];
      default: carh = 1'b0;
    endcase
    carh = carh ^ car_inv_q; // see R8
    if (!enable_q) begin
      carh = 1'b0; // disabled carrier goes to ground
    end
  end

  // low carrier arrives selected; apply its polarity here
  assign carl = enable_q & (low_in.carrier ^ low_in.invert);

  // ----------------------------------------------------------------
  // carrier switching and output mixing
  // ----------------------------------------------------------------
  // effective gates: a synced carrier uses its held state
  assign high_act = car_sync_q ? high_act_q : modulator; // see R10
  assign low_act = low_in.sync ? low_act_q : !modulator;
  assign mixed = (high_act & carh) | (low_act & carl); // see R16 R17

  // next gates, carrier history and output
  always_comb begin
    carh_prev_d = carh;
    carl_prev_d = carl;
    high_act_d = carrier_gate(modulator, car_sync_q, high_act_q, carh, carh_prev_q); // see R9 R18
    low_act_d = carrier_gate(!modulator, low_in.sync, low_act_q, carl, carl_prev_q); // see R18
    out_d = 1'b0;
    if (enable_q) begin
      out_d = mixed ^ polarity_q; // see R1 R2
    end
  end

  // gates and output start idle after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_act_q <= 1'b0;
      low_act_q <= 1'b0;
      carh_prev_q <= 1'b0;
      carl_prev_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      high_act_q <= high_act_d;
      low_act_q <= low_act_d;
      carh_prev_q <= carh_prev_d;
      carl_prev_q <= carl_prev_d;
      out_q <= out_d;
    end
  end

  // output pin straight from the flop
  assign modulated_out = out_q;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always_comb begin
    enable_d = enable_q;
    polarity_d = polarity_q;
    swbit_d = swbit_q;
    mod_sel_d = mod_sel_q;
    car_sel_d = car_sel_q;
    car_inv_d = car_inv_q;
    car_sync_d = car_sync_q;
    if (reg_write) begin
      if (addr_hit(reg_addr, dsm_pkg::ADDR_CONTROL)) begin
        enable_d = reg_wdata[dsm_pkg::CTRL_ENABLE_POS];
        polarity_d = reg_wdata[dsm_pkg::CTRL_POLARITY_POS];
        swbit_d = reg_wdata[dsm_pkg::CTRL_SWBIT_POS];
      end else if (addr_hit(reg_addr, dsm_pkg::ADDR_SOURCE)) begin
        mod_sel_d = reg_wdata[dsm_pkg::SEL_W-1:0];
      end else if (addr_hit(reg_addr, dsm_pkg::ADDR_CARRIER_HIGH)) begin
        car_inv_d = reg_wdata[dsm_pkg::CARH_INVERT_POS];
        car_sync_d = reg_wdata[dsm_pkg::CARH_SYNC_POS];
        car_sel_d = reg_wdata[dsm_pkg::SEL_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // read mux; idle cycles and the unmapped index return zero
  always_comb begin
    rdata_d = dsm_pkg::READ_ZERO;
    if (reg_read) begin
      if (addr_hit(reg_addr, dsm_pkg::ADDR_CONTROL)) begin
        rdata_d = ctrl_image(enable_q, polarity_q, out_q, swbit_q); // see R3 R13
      end else if (addr_hit(reg_addr, dsm_pkg::ADDR_SOURCE)) begin
        rdata_d = {4'h0, mod_sel_q}; // see R14
      end else if (addr_hit(reg_addr, dsm_pkg::ADDR_CARRIER_HIGH)) begin
        rdata_d = {1'b0, car_inv_q, car_sync_q, 1'b0, car_sel_q};
      end
    end
  end

  // control bits clear on every reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= dsm_pkg::CTRL_RESET; // see R19 R15
      polarity_q <= dsm_pkg::CTRL_RESET;
      swbit_q <= dsm_pkg::CTRL_RESET;
      rdata_q <= dsm_pkg::READ_ZERO;
    end else begin
      enable_q <= enable_d;
      polarity_q <= polarity_d;
      swbit_q <= swbit_d;
      rdata_q <= rdata_d;
    end
  end

  // select fields are not reset and keep their value
  always_ff @(posedge clk) begin
    mod_sel_q <= mod_sel_d; // see R15
    car_sel_q <= car_sel_d;
    car_inv_q <= car_inv_d;
    car_sync_q <= car_sync_d;
  end

  // read data from the flop, one cycle after the strobe
  assign reg_rdata = rdata_q;

endmodule

`default_nettype wire

// ==== dsm_pkg.sv ====
// package: register map, field layout, select codes and carriers for the modulator
package dsm_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 2;
  localparam int unsigned DATA_W = 8;
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_SOURCE = 2'h1;
  localparam logic [1:0] ADDR_CARRIER_HIGH = 2'h2;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_ENABLE_POS = 7;
  localparam int unsigned CTRL_POLARITY_POS = 4;
  localparam int unsigned CTRL_STATUS_POS = 3;
  localparam int unsigned CTRL_SWBIT_POS = 0;
  localparam int unsigned CARH_INVERT_POS = 6;
  localparam int unsigned CARH_SYNC_POS = 5;
  localparam int unsigned SEL_W = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic CTRL_RESET = 1'b0;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam int unsigned SYNC_STAGES = 3;

  // ----------------------------------------------------------------
  // modulation source select codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MS_SOFTWARE = 4'h0, MS_PIN = 4'h1, MS_CAPTURE_COMPARE_ONE = 4'h2, MS_CAPTURE_COMPARE_TWO = 4'h3,
    MS_PULSE_WIDTH_UNIT_FIVE = 4'h4, MS_PULSE_WIDTH_UNIT_SIX = 4'h5, MS_CMP1 = 4'h6, MS_CMP2 = 4'h7,
    MS_SDO = 4'h8, MS_RESERVED = 4'h9, MS_TX = 4'hA, MS_NCO = 4'hB,
    MS_LOGIC_CELL_ONE = 4'hC, MS_CLC2 = 4'hD, MS_CLC3 = 4'hE, MS_LOGIC_CELL_FOUR = 4'hF
  } dsm_mod_sel_t;

  // ----------------------------------------------------------------
  // high carrier select codes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CH_GROUND = 4'h0, CH_PIN1 = 4'h1, CH_PIN2 = 4'h2, CH_REFCLK = 4'h3,
    CH_CAPTURE_COMPARE_ONE = 4'h4, CH_CAPTURE_COMPARE_TWO = 4'h5, CH_PULSE_WIDTH_UNIT_FIVE = 4'h6, CH_PULSE_WIDTH_UNIT_SIX = 4'h7,
    CH_NCO = 4'h8, CH_RESERVED = 4'h9, CH_SYSCLK = 4'hA, CH_FASTOSC = 4'hB,
    CH_LOGIC_CELL_ONE = 4'hC, CH_CLC2 = 4'hD, CH_CLC3 = 4'hE, CH_LOGIC_CELL_FOUR = 4'hF
  } dsm_car_sel_t;

  // ----------------------------------------------------------------
  // source groups
  // ----------------------------------------------------------------
  // on-chip peripheral outputs, same clock domain
  typedef struct packed {
    logic capture_compare_one;
    logic capture_compare_two;
    logic pulse_width_unit_five;
    logic pulse_width_unit_six;
    logic cmp1;
    logic cmp2;
    logic sdo;
    logic tx;
    logic nco;
    logic [3:0] clc;
  } dsm_periph_t;

  // pins and foreign clocks, asynchronous to clk
  typedef struct packed {
    logic mod_pin;
    logic car_pin1;
    logic car_pin2;
    logic refclk;
    logic sysclk;
    logic fastosc;
  } dsm_async_t;

  localparam int unsigned ASYNC_W = $bits(dsm_async_t);

  // low carrier path, selected outside this block
  typedef struct packed {
    logic carrier;
    logic invert;
    logic sync;
  } dsm_low_t;

endpackage

// ==== dsm_sync.sv ====
// module: three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none

module dsm_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
  logic [WIDTH-1:0] s1_d, s2_d, s3_d, out_d;

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  // a bit only changes once stages two and three agree
  always_comb begin
    s1_d = async_in;
    s2_d = s1_q;
    s3_d = s2_q;
    out_d = out_q;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;

endmodule

`default_nettype wire

// ==== dsm_ctrl_sva.sv ====
// checker: register readback, enable gating and output mixing of the modulator
`timescale 1ns/100ps
`default_nettype none

module dsm_ctrl_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire dsm_pkg::dsm_low_t low_in,
  input wire logic modulated_out
);
  // ----------
  // register mirror
  // ----------
  logic en_q, pol_q, sw_q;
  logic [3:0] msel_q;
  logic [7:0] carh_q;

  // control bits clear on every reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 1'b0;
      pol_q <= 1'b0;
      sw_q <= 1'b0;
    end else if (reg_write && reg_addr == dsm_pkg::ADDR_CONTROL) begin
      en_q <= reg_wdata[7];
      pol_q <= reg_wdata[4];
      sw_q <= reg_wdata[0];
    end
  end

  // select fields survive reset
  always_ff @(posedge clk) begin
    if (rst_n && reg_write && reg_addr == dsm_pkg::ADDR_SOURCE) begin
      msel_q <= reg_wdata[3:0];
    end
    if (rst_n && reg_write && reg_addr == dsm_pkg::ADDR_CARRIER_HIGH) begin
      carh_q <= reg_wdata & 8'h6F;
    end
  end

  // ----------
  // properties
  // ----------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  a_ctrl_read: assert property ($past(reg_read && reg_addr == dsm_pkg::ADDR_CONTROL)
    |-> (reg_rdata & 8'hF7) == {en_q, 2'b00, pol_q, 1'b0, 2'b00, sw_q})
    else $error("control readback wrong");
  a_src_read: assert property ($past(reg_read && reg_addr == dsm_pkg::ADDR_SOURCE)
    |-> reg_rdata == {4'h0, msel_q})
    else $error("source readback wrong");
  a_carh_read: assert property ($past(reg_read && reg_addr == dsm_pkg::ADDR_CARRIER_HIGH)
    |-> reg_rdata == carh_q)
    else $error("high carrier readback wrong");
  a_unmapped: assert property ($past(reg_read && reg_addr == 2'h3) |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_disabled_low: assert property (!en_q |=> !modulated_out)
    else $error("output active while disabled");
  a_sw_mod: assert property (en_q && !pol_q && sw_q && msel_q == 4'h0 && carh_q == 8'h40
    |=> modulated_out)
    else $error("software bit not mixed with high carrier");
  a_pol_idle: assert property (en_q && pol_q && !sw_q && msel_q == 4'h0 && !carh_q[5]
    && !low_in.sync && !(low_in.carrier ^ low_in.invert) && $stable(low_in) |=> modulated_out)
    else $error("inverted output does not idle high");

  c_out_high: cover property (en_q && modulated_out);
  c_unmapped: cover property (reg_read && reg_addr == 2'h3);
  c_sync_high: cover property (en_q && carh_q[5] && modulated_out);
endmodule

bind dsm_ctrl dsm_ctrl_sva u_sva (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .low_in(low_in),
  .modulated_out(modulated_out));

`default_nettype wire

// ==== dsm_partner.sv ====
// model: peripheral outputs, remapped pins and low carrier feeding the modulator
`timescale 1ns/100ps
`default_nettype none

module dsm_partner (
  input wire logic clk,
  input wire dsm_pkg::dsm_periph_t want_p,
  input wire dsm_pkg::dsm_async_t want_a,
  input wire dsm_pkg::dsm_low_t want_l,
  output var dsm_pkg::dsm_periph_t periph_in,
  output var dsm_pkg::dsm_async_t async_in,
  output var dsm_pkg::dsm_low_t low_in
);
  // quiet sources until the first edge
  initial begin
    periph_in = '0;
    async_in = '0;
    low_in = '0;
  end

  // same-clock sources change just after the edge
  always @(posedge clk) begin
    periph_in <= want_p;
    low_in <= want_l;
  end

  // pins move off the clock grid, as an unrelated source would
  always @(posedge clk) async_in <= #13 want_a;
endmodule

`default_nettype wire

// ==== dsm_ctrl_bench.sv ====
// testbench: registers, source and carrier selection, sync and reset of the modulator
`timescale 1ns/100ps
`default_nettype none

module dsm_ctrl_bench;
  // ----------
  // signals
  // ----------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic rd_seen = 1'b0;
  logic [7:0] reg_rdata;
  logic modulated_out;
  dsm_pkg::dsm_periph_t periph_in, wp = '0;
  dsm_pkg::dsm_async_t async_in, wa = '0;
  dsm_pkg::dsm_low_t low_in, wl = '0;
  logic en = 1'b0, pol = 1'b0, sw = 1'b0;
  logic [3:0] msel = 4'h0;
  logic [7:0] carh = 8'h00;
  logic [31:0] seed = 32'h02E989FE, r;
  int k;
  logic [7:0] rq[$];
  logic oq[$];
  int fail_count = 0;
  int samples_checked = 0;

  initial forever #25 clk = ~clk;

  dsm_ctrl dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .periph_in(periph_in), .async_in(async_in), .low_in(low_in),
    .modulated_out(modulated_out));
  dsm_partner far (.clk(clk), .want_p(wp), .want_a(wa), .want_l(wl), .periph_in(periph_in),
    .async_in(async_in), .low_in(low_in));

  // ----------
  // helpers
  // ----------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected output for static sources with sync off
  function automatic logic calc();
    logic [15:0] ms, cs;
    logic m, h, l;
    ms = {wp.clc, wp.nco, wp.tx, 1'b0, wp.sdo, wp.cmp2, wp.cmp1, wp.pulse_width_unit_six, wp.pulse_width_unit_five, wp.capture_compare_two, wp.capture_compare_one, wa.mod_pin, sw};
    cs = {wp.clc, wa.fastosc, wa.sysclk, 1'b0, wp.nco, wp.pulse_width_unit_six, wp.pulse_width_unit_five, wp.capture_compare_two, wp.capture_compare_one, wa.refclk,
      wa.car_pin2, wa.car_pin1, 1'b0};
    m = ms[msel];
    h = cs[carh[3:0]] ^ carh[6];
    l = wl.carrier ^ wl.invert;
    return en & (((m & h) | (~m & l)) ^ pol);
  endfunction

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    rq.push_back(e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
  endtask

  // control write with ones in every read-only place
  task automatic ctl(input logic e, input logic p, input logic s);
    en = e;
    pol = p;
    sw = s;
    wr(dsm_pkg::ADDR_CONTROL, {e, 2'b11, p, 1'b1, 2'b11, s});
  endtask

  // settle, then read control; status and pin compared together
  task automatic chk(input logic e);
    repeat (6) @(posedge clk);
    oq.push_back(e);
    rd(dsm_pkg::ADDR_CONTROL, {en, 2'b00, pol, e, 2'b00, sw});
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------
  // monitor
  // ----------
  always @(posedge clk) rd_seen <= reg_read;

  always @(negedge clk) begin
    if (rd_seen) begin
      cmp(reg_rdata, rq.pop_front());
      if (oq.size() > 0) cmp({7'h00, modulated_out}, {7'h00, oq.pop_front()});
    end
  end

  // ----------
  // scenarios
  // ----------
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(dsm_pkg::ADDR_CONTROL, 8'h00);
    wr(2'h3, 8'hFF);
    rd(2'h3, 8'h00);
    wr(dsm_pkg::ADDR_SOURCE, 8'hF0);
    rd(dsm_pkg::ADDR_SOURCE, 8'h00);
    wr(dsm_pkg::ADDR_CARRIER_HIGH, 8'hFF);
    rd(dsm_pkg::ADDR_CARRIER_HIGH, 8'h6F);
    carh = 8'h40;
    wr(dsm_pkg::ADDR_CARRIER_HIGH, carh);
    ctl(1'b1, 1'b0, 1'b1);
    chk(1'b1);
    ctl(1'b1, 1'b1, 1'b0);
    chk(1'b1);
    ctl(1'b0, 1'b1, 1'b1);
    chk(1'b0);
    // sweep of every source and carrier code with random levels
    for (int i = 0; i < 48; i++) begin
      r = xs();
      k = i * 5;
      msel = i[3:0];
      carh = {1'b0, r[27], 2'b00, k[3:0]};
      wp <= r[12:0];
      wa <= r[18:13];
      wl <= {r[21:20], 1'b0};
      wr(dsm_pkg::ADDR_SOURCE, {r[7:4], msel});
      wr(dsm_pkg::ADDR_CARRIER_HIGH, carh);
      ctl(r[31] | r[30], r[29], r[28]);
      chk(calc());
    end
    // high carrier synchronised to its falling edge
    wp <= '0;
    wl <= '0;
    wr(dsm_pkg::ADDR_SOURCE, 8'h00);
    wr(dsm_pkg::ADDR_CARRIER_HIGH, 8'h24);
    ctl(1'b1, 1'b0, 1'b1);
    wp.capture_compare_one <= 1'b1;
    repeat (3) @(posedge clk);
    wp.capture_compare_one <= 1'b0;
    repeat (3) @(posedge clk);
    wp.capture_compare_one <= 1'b1;
    chk(1'b1);
    ctl(1'b1, 1'b0, 1'b0);
    chk(1'b1);
    wp.capture_compare_one <= 1'b0;
    chk(1'b0);
    // without sync the switch is immediate
    wr(dsm_pkg::ADDR_CARRIER_HIGH, 8'h04);
    wp.capture_compare_one <= 1'b1;
    ctl(1'b1, 1'b0, 1'b1);
    chk(1'b1);
    ctl(1'b1, 1'b0, 1'b0);
    chk(1'b0);
    // second reset clears control and keeps the high carrier select
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(dsm_pkg::ADDR_CONTROL, 8'h00);
    rd(dsm_pkg::ADDR_CARRIER_HIGH, 8'h04);
    print_verdict();
  end

  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    print_verdict();
  end
endmodule

`default_nettype wire
